// ==== hw/dcc_pkg.sv ====
// constants, types and rule summary for the drum channel control block
// How it works
// RQ1: after a mid-sector stop, host reloads an address with zero byte field first
// RQ2: simultaneous connects get no fixed priority; first request seen wins
// RQ3: a connected channel keeps the controller reserved until it releases
// RQ4: host selects a mode before every buffer it starts
// RQ5: end of operation of each buffer clears the selected mode
// RQ6: a buffer conflicting with the mode gets no response and hangs
// RQ7: any master clear zeroes the address and drops all interrupt selections; a channel's CMD_MCLEAR drops only that channel's selections
// RQ8: release and disconnect keeps address and interrupt selections
// RQ9: only a manual master clear removes not ready
// RQ10: pending interrupt withdrawn by master clear, release, or 002-/003- codes
// RQ11: interrupt selections are kept per channel, untouched by the other channel
// RQ12: reserving channel gets all selected interrupts, other only release interrupt
// RQ13: on writes, end of operation waits until the last byte is written
// RQ14: interlace delay equals per-byte time, 1 to 32 microseconds by ratio; the code takes INTERLACE up to 7, giving up to 128 microseconds
// RQ15: head group change on last byte adds 100 microseconds to the delay
// RQ16: one-byte write ends only after the byte is written, up to 35 ms
// RQ17: on dc power, remote-start units power up in sequence, local ones skipped
// RQ18: remote units ignore own buttons; local units ignore controller power
// RQ19: remote units all power off together at shutdown
// RQ20: address advances by one per byte except on write check error
// RQ21: sector drum with nonzero byte field raises lost data at initiation
package dcc_pkg;
	localparam int CLK_MHZ = 100;
	localparam int ADDR_W = 22;
	localparam int BYTE_FIELD_W = 7;
	localparam int HEAD_LSB = 15;
	localparam int HEAD_W = 6;
	localparam int UNITS = 8;
	localparam int INTERLACE_BASE_US = 1;
	localparam int HEAD_SWITCH_US = 100;
	localparam int REV_MS = 35;
	localparam int HEAD_SWITCH_CYC = HEAD_SWITCH_US * CLK_MHZ;
	localparam int US_CYC = INTERLACE_BASE_US * CLK_MHZ;
	localparam int REV_CYC = REV_MS * 1000 * CLK_MHZ;
	localparam int UNIT_STEP_CYC = 1000;
	localparam int CNT_W = 24;
	localparam logic [ADDR_W-1:0] ADDR_RST = 22'h000000;
	// wishbone register offsets
	localparam logic [3:0] OFS_CMD = 4'h0;
	localparam logic [3:0] OFS_ADDR = 4'h4;
	localparam logic [3:0] OFS_ISEL = 4'h8;
	localparam logic [3:0] OFS_STAT = 4'hc;
	// command field of OFS_CMD, bits 3:0
	localparam logic [3:0] CMD_CONNECT = 4'h1;
	localparam logic [3:0] CMD_RELEASE = 4'h2;
	localparam logic [3:0] CMD_MCLEAR = 4'h3;
	localparam logic [3:0] CMD_MODE_RD = 4'h4;
	localparam logic [3:0] CMD_MODE_WR = 4'h5;
	localparam logic [3:0] CMD_GRP2 = 4'h6;
	localparam logic [3:0] CMD_GRP3 = 4'h7;
	localparam logic [3:0] CMD_LOADADDR = 4'h8;
	localparam int CMD_CH_BIT = 4;
	typedef enum logic [1:0] {MODE_NONE = 2'b00, MODE_RD = 2'b01, MODE_WR = 2'b11} dcc_mode_t;
	typedef enum logic [1:0] {EW_IDLE = 2'b00, EW_WAIT = 2'b01, EW_DONE = 2'b11} dcc_ew_t;
	typedef struct packed {
		logic [31:0] dat_r;
		logic ack;
		logic res_valid;
		logic res_ch;
		dcc_mode_t mode;
		dcc_ew_t ew;
		logic [CNT_W-1:0] cnt;
		logic [ADDR_W-1:0] addr;
		logic [1:0][3:0] isel;
		logic [1:0][3:0] ipend;
		logic not_ready;
		logic lost_data;
		logic eop;
		logic [1:0] irq;
		logic dc_prev;
		logic [3:0] seq_unit;
		logic seq_run;
		logic [CNT_W-1:0] seq_cnt;
		logic [UNITS-1:0] unit_pwr;
		logic byte_ack;
		logic [ADDR_W-1:0] last_addr;
	} dcc_state_t;
endpackage : dcc_pkg

// ==== hw/dcc_top.sv ====
// drum channel control: reservation, modes, clears, interrupts, write end delay, power
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
module dcc_top import dcc_pkg::*; #(
	parameter int REV_CYCLES = REV_CYC,
	parameter int STEP_CYCLES = UNIT_STEP_CYC,
	parameter bit SECTOR_DRUM = 1'b0
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// wishbone slave
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire logic [3:0] WB_ADR,
	input wire logic [3:0] WB_SEL,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK,
	// data path from channel
	input wire logic BYTE_REQ,
	input wire logic BYTE_CH,
	input wire logic BYTE_IS_WRITE,
	input wire logic BUF_LAST,
	input wire logic BUF_ONE,
	input wire logic WCHK_ERR,
	input wire logic [2:0] INTERLACE,
	output logic BYTE_ACK,
	output logic EOP,
	output logic LOST_DATA,
	// interrupts and status to channels
	output logic [1:0] CH_IRQ,
	output logic RESERVED,
	output logic RESERVED_CH,
	// manual and power
	input wire logic MANUAL_MCLEAR,
	input wire logic NOT_READY_IN,
	input wire logic DC_POWER,
	input wire logic [UNITS-1:0] UNIT_REMOTE,
	input wire logic [UNITS-1:0] UNIT_LOCAL_ON,
	output logic NOT_READY,
	output logic [UNITS-1:0] UNIT_POWER
);
	initial begin
		if (REV_CYCLES < 1 || REV_CYCLES >= (1 << CNT_W)) begin
			$error("dcc_top: REV_CYCLES out of range");
		end
		if (STEP_CYCLES < 1 || STEP_CYCLES >= (1 << CNT_W)) begin
			$error("dcc_top: STEP_CYCLES out of range");
		end
		if (UNITS < 1 || UNITS > 8) begin
			$error("dcc_top: sequencer serves at most eight units");
		end
		if (HEAD_SWITCH_CYC + (US_CYC << 5) >= (1 << CNT_W)) begin
			$error("dcc_top: wait counter too narrow");
		end
	end

	localparam int IRQ_RELEASE = 0;

	// end-of-operation wait in cycles for the last byte of a write buffer
	function automatic logic [CNT_W-1:0] write_end_wait(
		input logic one_byte,
		input logic head_change,
		input logic [CNT_W-1:0] interlace_cyc
	);
		logic [CNT_W-1:0] w;
		w = interlace_cyc; // see RQ14
		if (one_byte) begin
			w = CNT_W'(REV_CYCLES); // see RQ16
		end else if (head_change) begin
			w = CNT_W'(HEAD_SWITCH_CYC) + interlace_cyc; // see RQ15
		end
		return w;
	endfunction : write_end_wait

	// status word as software reads it
	function automatic logic [31:0] status_word(input dcc_state_t st);
		logic [31:0] w;
		w = 32'h00000000;
		w[0] = st.res_valid;
		w[1] = st.res_ch;
		w[3:2] = st.mode;
		w[4] = st.lost_data;
		w[5] = st.not_ready;
		w[6] = st.ipend[0][IRQ_RELEASE];
		w[7] = st.ipend[1][IRQ_RELEASE];
		return w;
	endfunction : status_word

	// a byte is taken only when its direction agrees with the selected mode
	function automatic logic dir_matches(input logic is_write, input dcc_mode_t m);
		logic ok;
		unique case (m)
			MODE_RD: ok = !is_write;
			MODE_WR: ok = is_write;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : dir_matches

	// reserving channel sees every selected interrupt, the other only release
	function automatic logic irq_steer(
		input logic owner,
		input logic [3:0] pend,
		input logic [3:0] sel
	);
		logic hit;
		if (owner) begin
			hit = |(pend & sel);
		end else begin
			hit = pend[IRQ_RELEASE] & sel[IRQ_RELEASE];
		end
		return hit;
	endfunction : irq_steer

	dcc_state_t s, n;

	logic wb_req;
	logic wb_wr;
	logic [3:0] cmd;
	logic cmd_ch;
	logic cmd_wr;
	logic [CNT_W-1:0] il_cyc;
	logic [ADDR_W-1:0] next_addr;
	always_comb begin
		wb_req = WB_CYC && WB_STB && !s.ack;
		// writes land at the edge that shows ack, while the master still holds them
		wb_wr = WB_CYC && WB_STB && WB_WE && s.ack;
		cmd_wr = wb_wr && WB_ADR == OFS_CMD && WB_SEL[0];
		cmd = WB_DAT_I[3:0];
		cmd_ch = WB_DAT_I[CMD_CH_BIT];
		il_cyc = CNT_W'(US_CYC) << INTERLACE; // see RQ14
		next_addr = s.addr + ADDR_W'(1);
	end

	always_comb begin
		n = s;
		n.ack = wb_req;
		n.eop = 1'b0;
		n.byte_ack = 1'b0;
		if (NOT_READY_IN) begin
			n.not_ready = 1'b1;
		end
		if (wb_req && !WB_WE) begin
			unique case (WB_ADR)
				OFS_ADDR: n.dat_r = 32'(s.addr);
				OFS_ISEL: n.dat_r = {24'h000000, s.isel[1], s.isel[0]};
				OFS_STAT: n.dat_r = status_word(s);
				default: n.dat_r = 32'h00000000;
			endcase
		end
		if (wb_wr && WB_ADR == OFS_ISEL && WB_SEL[0]) begin
			n.isel[WB_DAT_I[8]] = WB_DAT_I[3:0]; // see RQ11
		end
		if (wb_wr && WB_ADR == OFS_ADDR && WB_SEL[0] && (!s.res_valid)) begin
			n.addr = WB_DAT_I[ADDR_W-1:0];
		end
		if (cmd_wr) begin
			unique case (cmd)
				CMD_CONNECT: begin
					// first request taken wins; others are dropped and must be sent again after release
					if (!s.res_valid) begin // see RQ2
						n.res_valid = 1'b1; // see RQ3
						n.res_ch = cmd_ch;
					end
				end
				CMD_RELEASE: begin
					if (s.res_valid && s.res_ch == cmd_ch) begin
						n.res_valid = 1'b0;
						n.mode = MODE_NONE;
						n.ipend[!cmd_ch][IRQ_RELEASE] = s.isel[!cmd_ch][IRQ_RELEASE];
					end
					n.ipend[cmd_ch] = 4'h0; // see RQ8 see RQ10
				end
				CMD_MCLEAR: begin
					n.addr = ADDR_RST; // see RQ7
					n.isel[cmd_ch] = 4'h0;
					n.ipend[cmd_ch] = 4'h0; // see RQ10
					n.mode = MODE_NONE;
					n.lost_data = 1'b0;
					if (s.res_ch == cmd_ch) begin
						n.res_valid = 1'b0;
					end
				end
				CMD_MODE_RD, CMD_MODE_WR: begin
					if (s.res_valid && s.res_ch == cmd_ch) begin
						n.mode = (cmd == CMD_MODE_RD) ? MODE_RD : MODE_WR;
						if (SECTOR_DRUM && s.addr[BYTE_FIELD_W-1:0] != 7'h00) begin
							n.lost_data = 1'b1; // see RQ21
						end
					end
				end
				CMD_GRP2, CMD_GRP3: begin
					n.ipend[cmd_ch] = 4'h0; // see RQ10
					if (cmd == CMD_GRP2) begin
						n.isel[cmd_ch] = WB_DAT_I[11:8];
					end
				end
				default: begin
				end
			endcase
		end
		if (MANUAL_MCLEAR) begin
			n.addr = ADDR_RST; // see RQ7
			n.isel = '0;
			n.ipend = '0; // see RQ10
			n.mode = MODE_NONE;
			n.res_valid = 1'b0;
			n.lost_data = 1'b0;
			n.not_ready = NOT_READY_IN; // see RQ9
		end
		// byte transfers only when direction matches the mode
		if (BYTE_REQ && s.res_valid && BYTE_CH == s.res_ch && s.ew == EW_IDLE
				&& dir_matches(BYTE_IS_WRITE, s.mode)
				&& !s.byte_ack) begin // see RQ6
			n.byte_ack = 1'b1;
			n.last_addr = s.addr;
			if (!WCHK_ERR) begin
				n.addr = next_addr; // see RQ20
			end
			if (BUF_LAST) begin
				if (BYTE_IS_WRITE) begin
					n.ew = EW_WAIT; // see RQ13
					n.cnt = write_end_wait(BUF_ONE,
						s.addr[HEAD_LSB+:HEAD_W] != s.last_addr[HEAD_LSB+:HEAD_W],
						il_cyc); // see RQ14 see RQ15 see RQ16
				end else begin
					n.eop = 1'b1;
					n.mode = MODE_NONE; // see RQ5
				end
			end
		end
		unique case (s.ew)
			EW_IDLE: begin
			end
			EW_WAIT: begin
				if (s.cnt <= CNT_W'(1)) begin
					n.ew = EW_DONE;
				end else begin
					n.cnt = s.cnt - CNT_W'(1);
				end
			end
			EW_DONE: begin
				n.eop = 1'b1; // see RQ13
				n.mode = MODE_NONE; // see RQ5
				n.ew = EW_IDLE;
			end
			default: n.ew = EW_IDLE;
		endcase
		// interrupt steering
		for (int c = 0; c < 2; c++) begin
			n.irq[c] = irq_steer(s.res_valid && s.res_ch == c[0], s.ipend[c], s.isel[c]); // see RQ12
		end
		// a manual clear drops the lines at once, not a cycle later
		if (MANUAL_MCLEAR) begin
			n.irq = 2'b00; // see RQ7
		end
		if (s.eop && s.res_valid) begin
			n.ipend[s.res_ch][1] = 1'b1;
		end
		// power sequencing
		n.dc_prev = DC_POWER;
		for (int u = 0; u < UNITS; u++) begin
			if (!UNIT_REMOTE[u]) begin
				n.unit_pwr[u] = UNIT_LOCAL_ON[u]; // see RQ18
			end else if (!DC_POWER) begin
				n.unit_pwr[u] = 1'b0; // see RQ19
			end
		end
		if (DC_POWER && !s.dc_prev) begin
			n.seq_run = 1'b1; // see RQ17
			n.seq_unit = 4'h0;
			n.seq_cnt = '0;
		end else if (s.seq_run && DC_POWER) begin
			if (s.seq_unit == 4'(UNITS)) begin
				n.seq_run = 1'b0;
			end else if (!UNIT_REMOTE[s.seq_unit[2:0]]) begin
				n.seq_unit = s.seq_unit + 4'h1; // see RQ17
			end else if (s.seq_cnt == CNT_W'(STEP_CYCLES - 1)) begin
				n.unit_pwr[s.seq_unit[2:0]] = 1'b1;
				n.seq_unit = s.seq_unit + 4'h1;
				n.seq_cnt = '0;
			end else begin
				n.seq_cnt = s.seq_cnt + CNT_W'(1);
			end
		end else if (!DC_POWER) begin
			n.seq_run = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	always_comb begin
		WB_DAT_O = s.dat_r;
		WB_ACK = s.ack;
		BYTE_ACK = s.byte_ack;
		EOP = s.eop;
		LOST_DATA = s.lost_data;
		CH_IRQ = s.irq;
		RESERVED = s.res_valid;
		RESERVED_CH = s.res_ch;
		NOT_READY = s.not_ready;
		UNIT_POWER = s.unit_pwr;
	end
endmodule : dcc_top

// ==== bench/dcc_asserts.sv ====
// checker for the drum channel control block
module dcc_asserts import dcc_pkg::*; (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// bus strobes and byte path
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire logic BYTE_ACK,
	input wire logic BYTE_IS_WRITE,
	input wire logic BUF_LAST,
	input wire logic BUF_ONE,
	input wire logic [2:0] INTERLACE,
	input wire logic EOP,
	// status and power
	input wire logic [1:0] CH_IRQ,
	input wire logic RESERVED,
	input wire logic RESERVED_CH,
	input wire logic MANUAL_MCLEAR,
	input wire logic NOT_READY,
	input wire logic DC_POWER,
	input wire logic [UNITS-1:0] UNIT_REMOTE,
	input wire logic [UNITS-1:0] UNIT_LOCAL_ON,
	input wire logic [UNITS-1:0] UNIT_POWER
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	AST_RD_EOP: assert property (BYTE_ACK && !BYTE_IS_WRITE && BUF_LAST |-> EOP)
		else $error("read end missing");
	AST_WR_HOLD: assert property (BYTE_ACK && BYTE_IS_WRITE && BUF_LAST |-> !EOP [*8])
		else $error("write end too early");
	AST_WR_DELAY: assert property (
		BYTE_ACK && BYTE_IS_WRITE && BUF_LAST && !BUF_ONE && INTERLACE == 3'h0 |-> ##[95:110] EOP)
		else $error("write end delay wrong");
	AST_NRDY: assert property (NOT_READY && !MANUAL_MCLEAR |=> NOT_READY)
		else $error("not ready lost");
	AST_MCLR: assert property (MANUAL_MCLEAR |=> !RESERVED && CH_IRQ == 2'b00)
		else $error("manual clear incomplete");
	AST_RESV: assert property (
		RESERVED && !(WB_CYC && WB_STB && WB_WE) && !MANUAL_MCLEAR
		|=> RESERVED && $stable(RESERVED_CH)) else $error("reservation lost");
	AST_SEQ: assert property ($countones(UNIT_POWER & ~$past(UNIT_POWER) & UNIT_REMOTE) <= 1)
		else $error("units not sequenced");
	AST_OFF: assert property ($fell(DC_POWER) |-> ##[1:2] (UNIT_POWER & UNIT_REMOTE) == 8'h00)
		else $error("remote units not off");
	AST_LOCAL: assert property (
		$stable(UNIT_LOCAL_ON) && $stable(UNIT_REMOTE) |=> $stable(UNIT_POWER & ~UNIT_REMOTE))
		else $error("local unit disturbed");
	cover property (EOP && BYTE_IS_WRITE);
	cover property ($fell(DC_POWER));
	cover property (RESERVED && !RESERVED_CH);
endmodule : dcc_asserts
bind dcc_top dcc_asserts i_dcc_asserts (.*);

// ==== bench/dcc_chan.sv ====
// partner model: a data channel offering bytes and waiting for the reply
module dcc_chan (
	// clock
	input wire logic REF_CLK,
	// byte handshake
	input wire logic BYTE_ACK,
	output logic BYTE_REQ,
	output logic BYTE_CH,
	output logic BYTE_IS_WRITE,
	output logic BUF_LAST,
	output logic BUF_ONE
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {BYTE_REQ, BYTE_CH, BYTE_IS_WRITE, BUF_LAST, BUF_ONE} = 5'h00;
	task automatic xfer(input logic c, input logic w, input logic l, input logic o, output bit ok);
		int n;
		n = 0;
		@(posedge REF_CLK);
		{BYTE_REQ, BYTE_CH, BYTE_IS_WRITE, BUF_LAST, BUF_ONE} <= {1'b1, c, w, l, o};
		// hold the byte until the reply, give up after 20 cycles
		do begin
			@(posedge REF_CLK);
			n++;
		end while (BYTE_ACK !== 1'b1 && n < 20);
		ok = BYTE_ACK === 1'b1;
		// released lines show the inverse of their last value
		{BYTE_REQ, BYTE_CH, BYTE_IS_WRITE, BUF_LAST, BUF_ONE} <= {1'b0, ~c, ~w, ~l, ~o};
	endtask : xfer
endmodule : dcc_chan

// ==== bench/tb.sv ====
// self-checking bench for the drum channel control block
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %h seen %h", n, e, a); end end
module tb import dcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic REF_CLK = 0, RESETN = 0, WB_CYC = 0, WB_STB = 0, WB_WE = 0;
	logic [3:0] WB_ADR = 0, WB_SEL = 4'hf;
	logic [31:0] WB_DAT_I = 0, WB_DAT_O, r, e_w;
	logic WB_ACK, BYTE_REQ, BYTE_CH, BYTE_IS_WRITE, BUF_LAST, BUF_ONE, BYTE_ACK, EOP, LOST_DATA;
	logic WCHK_ERR = 0, MANUAL_MCLEAR = 0, NOT_READY_IN = 0, DC_POWER = 0;
	logic [2:0] INTERLACE = 0;
	logic [1:0] CH_IRQ;
	logic RESERVED, RESERVED_CH, NOT_READY;
	logic [UNITS-1:0] UNIT_REMOTE = 0, UNIT_LOCAL_ON = 0, UNIT_POWER;
	logic [31:0] exp_q[$];
	int miscompares = 0, samples_checked = 0, seed = 59257, n, d;
	bit ok;
	dcc_top #(.REV_CYCLES(50), .STEP_CYCLES(4)) i_dcc_top (.*);
	dcc_chan i_dcc_chan (.*);
	initial forever #5 REF_CLK = ~REF_CLK;
	task automatic print_verdict;
		if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic tick(input int k);
		repeat (k) @(posedge REF_CLK);
	endtask : tick
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge REF_CLK);
		{WB_CYC, WB_STB, WB_WE, WB_ADR, WB_DAT_I} <= {2'b11, w, a, v};
		do @(posedge REF_CLK); while (WB_ACK !== 1'b1);
		{WB_CYC, WB_STB} <= 2'b00;
	endtask : wb
	task automatic wait_eop(input int lim, output int k);
		k = 0;
		while (EOP !== 1'b1 && k < lim) begin
			@(posedge REF_CLK);
			k++;
		end
	endtask : wait_eop
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask : rd
	initial begin
		#400us;
		miscompares++;
		print_verdict();
	end
	always @(posedge REF_CLK) begin
		if (WB_ACK === 1'b1 && WB_WE === 1'b0) begin
			e_w = exp_q.pop_front();
			`CHK("read data", e_w, WB_DAT_O)
		end
	end
	initial begin
		tick(4);
		RESETN <= 1;
		r = $random(seed) & 32'h3fff80;
		wb(1, OFS_ADDR, r);
		wb(1, OFS_ISEL, 32'h003);
		wb(1, OFS_ISEL, 32'h101);
		wb(1, OFS_CMD, 32'h01);
		wb(1, OFS_CMD, 32'h11);
		rd(OFS_STAT, 32'h1);
		wb(1, OFS_CMD, 32'h02);
		rd(OFS_ADDR, r);
		rd(OFS_ISEL, 32'h13);
		`CHK("irq", 2'b10, CH_IRQ)
		wb(1, OFS_CMD, 32'h13);
		rd(OFS_ADDR, 32'h0);
		rd(OFS_ISEL, 32'h03);
		`CHK("irq", 2'b00, CH_IRQ)
		wb(1, OFS_CMD, 32'h01);
		wb(1, OFS_CMD, 32'h04);
		i_dcc_chan.xfer(0, 0, 1, 0, ok);
		`CHK("read end", 1'b1, EOP)
		tick(2);
		`CHK("end irq", 2'b01, CH_IRQ)
		rd(OFS_STAT, 32'h1);
		wb(1, OFS_CMD, 32'h07);
		tick(2);
		`CHK("irq", 2'b00, CH_IRQ)
		for (int i = 0; i < 7; i++) begin
			INTERLACE <= 3'(i % 6);
			wb(1, OFS_CMD, 32'h05);
			i_dcc_chan.xfer(0, 1, 1, i == 6, ok);
			d = (i == 6) ? 50 : 100 << i;
			wait_eop(5000, n);
			`CHK("write end", 1'b1, n >= d && n <= d + 3)
		end
		rd(OFS_ADDR, 32'h8);
		wb(1, OFS_CMD, 32'h02);
		wb(1, OFS_ADDR, 32'h7fff);
		wb(1, OFS_CMD, 32'h01);
		INTERLACE <= 3'h1;
		wb(1, OFS_CMD, 32'h05);
		i_dcc_chan.xfer(0, 1, 0, 0, ok);
		i_dcc_chan.xfer(0, 1, 1, 0, ok);
		wait_eop(12000, n);
		`CHK("head switch end", 1'b1, n >= 10200 && n <= 10203)
		wb(1, OFS_CMD, 32'h04);
		i_dcc_chan.xfer(0, 1, 1, 0, ok);
		`CHK("hang", 1'b0, ok)
		NOT_READY_IN <= 1;
		tick(1);
		NOT_READY_IN <= 0;
		wb(1, OFS_CMD, 32'h03);
		tick(2);
		`CHK("not ready", 1'b1, NOT_READY)
		MANUAL_MCLEAR <= 1;
		tick(1);
		MANUAL_MCLEAR <= 0;
		tick(2);
		`CHK("clear", 5'h00, {NOT_READY, RESERVED, CH_IRQ, LOST_DATA})
		r = $random(seed);
		UNIT_REMOTE <= r[7:0] | 8'h01;
		tick(2);
		DC_POWER <= 1;
		tick(100);
		`CHK("remote up", UNIT_REMOTE, UNIT_POWER)
		UNIT_LOCAL_ON <= ~UNIT_REMOTE;
		tick(3);
		`CHK("local up", 8'hff, UNIT_POWER)
		DC_POWER <= 0;
		tick(3);
		`CHK("remote down", ~UNIT_REMOTE, UNIT_POWER)
		print_verdict();
	end
endmodule : tb
